// >>> pmg_pkg.sv
/*
 * shared constants and types for the pulse modulation generator.
 * assumes a 125 MHz core clock; all times held as 8 ns tick counts.
 */
package pmg_pkg;

	localparam int unsigned CLK_HZ       = 125000000;
	localparam int unsigned TW           = 32;

	// sync output delay limits, as printed
	localparam int unsigned SYNC_MIN_NS  = 100;
	localparam int unsigned SYNC_MAX_MS  = 10;
	// least time rounds up, longest rounds down
	localparam logic [31:0] SYNC_MIN_CYC =
		32'((SYNC_MIN_NS * 64'd125 + 999) / 1000);
	localparam logic [31:0] SYNC_MAX_CYC =
		32'(64'(SYNC_MAX_MS) * CLK_HZ / 1000);

	// reset values of the settings, in cycles
	localparam logic [31:0] PER_RST      = 32'h0001_e848;
	localparam logic [31:0] WID_RST      = 32'h0000_04e2;
	localparam logic [31:0] DLY_RST      = 32'h0000_0000;
	localparam logic [31:0] SYNC_RST     = 32'h0000_000d;

	typedef enum logic [1:0] {
		PMG_GEN_OFF  = 2'h0,
		PMG_SINGLE   = 2'h1,
		PMG_FREE     = 2'h2,
		PMG_WINDOW   = 2'h3
	} pmg_mode_t;

	// one-hot generator sequencer
	typedef enum logic [3:0] {
		PMG_S_IDLE   = 4'h1,
		PMG_S_DELAY  = 4'h2,
		PMG_S_PULSE  = 4'h4,
		PMG_S_REST   = 4'h8
	} pmg_state_t;

	typedef struct packed {
		logic          pulse_on;
		logic          flipped_polarity;
		logic          use_external;
		pmg_mode_t     mode;
		logic [TW-1:0] generator_period;
		logic [TW-1:0] generator_width;
		logic [TW-1:0] generator_delay;
		logic [TW-1:0] sync_output_delay;
	} pmg_cfg_t;

	typedef struct packed {
		logic          pulse_on;
		logic          flipped_polarity;
		logic          use_external;
		pmg_mode_t     mode;
		logic [TW-1:0] generator_period;
		logic [TW-1:0] generator_width;
		logic [TW-1:0] generator_delay;
		logic [TW-1:0] sync_output_delay;
	} pmg_stat_t;

endpackage

// >>> pmg_src.sv
/* external pulse and trigger source.
   assumes the bench sets gate_req on rising edges of core_clk. */
`timescale 1ns/1ns
module pmg_src (
	// clock
	input  wire logic core_clk,
	// bench request
	input  wire logic gate_req,
	// pins toward the device
	output logic      pulse_in,
	output logic      gate_or_fire_input
);
	initial begin
		pulse_in = 1'b0;
		gate_or_fire_input = 1'b0;
		forever begin
			@(posedge core_clk);
			pulse_in <= 1'($urandom);
			gate_or_fire_input <= gate_req;
		end
	end
endmodule // pmg_src

// >>> pmg_top.sv
/*
 * pulse modulation generator: selects internal generator or external
 * pulse to gate the radio output, plus a delayed sync output.
 * assumes pulse inputs are synchronous to core_clk and the command
 * side presents settings as cycle counts with a one-cycle write strobe.
 */
//
// Contract
// - normal polarity: rf on while pulse high
// - flipped polarity: rf on while pulse low; code flips external pulse_in only, not the generator pulse
// - polarity setting readable back
// - source select internal or external
// - external source uses rear pulse pin
// - source selection readable back
// - pulse modulation on/off state held
// - programmable generator delay, readable back
// - rate accepted; held as period cycles
// - rate readable back as period
// - mode off stops internal pulses
// - single_shot: one pulse per trigger
// - free_running: repeats without trigger
// - window: pulses only while gate high
// - period programmable directly
// - sync delay clamped 100 ns..10 ms
// - programmable generator width
// - width readable back
`timescale 1ns/1ns
module pmg_top (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// settings from command side
	input  wire logic              cfg_wr,
	input  wire pmg_pkg::pmg_cfg_t cfg_in,
	// external pins
	input  wire logic              pulse_in,
	input  wire logic              gate_or_fire_input,
	// outputs
	output logic                   radio_output,
	output logic                   sync_out,
	output pmg_pkg::pmg_stat_t     stat_out
);

	////////////////////////////////////////////////////////////////////
	// settings
	pmg_pkg::pmg_cfg_t    cfg_r;
	logic [31:0]          sync_clamp;

	always_comb begin
		if (cfg_in.sync_output_delay < pmg_pkg::SYNC_MIN_CYC)
			sync_clamp = pmg_pkg::SYNC_MIN_CYC;
		else if (cfg_in.sync_output_delay > pmg_pkg::SYNC_MAX_CYC)
			sync_clamp = pmg_pkg::SYNC_MAX_CYC;
		else
			sync_clamp = cfg_in.sync_output_delay;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_r.pulse_on          <= 1'b0;
			cfg_r.flipped_polarity  <= 1'b0;
			cfg_r.use_external      <= 1'b0;
			cfg_r.mode              <= pmg_pkg::PMG_GEN_OFF;
			cfg_r.generator_period  <= pmg_pkg::PER_RST;
			cfg_r.generator_width   <= pmg_pkg::WID_RST;
			cfg_r.generator_delay   <= pmg_pkg::DLY_RST;
			cfg_r.sync_output_delay <= pmg_pkg::SYNC_RST;
		end else if (cfg_wr) begin
			cfg_r                   <= cfg_in;
			cfg_r.generator_delay   <= cfg_in.generator_delay;
			cfg_r.generator_width   <= cfg_in.generator_width;
			cfg_r.sync_output_delay <= sync_clamp;
			// zero period is stored and read back as one
			if (cfg_in.generator_period == 32'h0000_0000)
				cfg_r.generator_period <= 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// readback shows the settings defaults straight out of reset
			stat_out.pulse_on          <= 1'b0;
			stat_out.flipped_polarity  <= 1'b0;
			stat_out.use_external      <= 1'b0;
			stat_out.mode              <= pmg_pkg::PMG_GEN_OFF;
			stat_out.generator_period  <= pmg_pkg::PER_RST;
			stat_out.generator_width   <= pmg_pkg::WID_RST;
			stat_out.generator_delay   <= pmg_pkg::DLY_RST;
			stat_out.sync_output_delay <= pmg_pkg::SYNC_RST;
		end else begin
			stat_out.pulse_on          <= cfg_r.pulse_on;
			stat_out.flipped_polarity  <= cfg_r.flipped_polarity;
			stat_out.use_external      <= cfg_r.use_external;
			stat_out.mode              <= cfg_r.mode;
			stat_out.generator_period  <= cfg_r.generator_period;
			stat_out.generator_width   <= cfg_r.generator_width;
			stat_out.generator_delay   <= cfg_r.generator_delay;
			stat_out.sync_output_delay <= cfg_r.sync_output_delay;
		end
	end

	////////////////////////////////////////////////////////////////////
	// trigger edge detect
	logic                 gate_d_r;
	logic                 fire_edge;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			gate_d_r <= 1'b0;
		else
			gate_d_r <= gate_or_fire_input;
	end

	assign fire_edge = gate_or_fire_input & ~gate_d_r;

	////////////////////////////////////////////////////////////////////
	// internal generator
	pmg_pkg::pmg_state_t  state_r;
	pmg_pkg::pmg_state_t  state_nxt;
	logic [31:0]          cnt_r;
	logic [31:0]          cnt_nxt;
	logic                 run_ok;
	logic                 start;
	logic                 gen_pulse;

	always_comb begin
		run_ok = 1'b0;
		start  = 1'b0;
		case (cfg_r.mode)
			pmg_pkg::PMG_FREE: begin
				run_ok = 1'b1;
				start  = 1'b1;
			end
			pmg_pkg::PMG_WINDOW: begin
				run_ok = gate_or_fire_input;
				start  = gate_or_fire_input;
			end
			pmg_pkg::PMG_SINGLE: begin
				// one start per rising trigger edge
				start  = fire_edge;
			end
			default: begin
				run_ok = 1'b0;
				start  = 1'b0;
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r - 32'h0000_0001;
		case (state_r)
			pmg_pkg::PMG_S_IDLE: begin
				cnt_nxt = cfg_r.generator_delay;
				if (start)
					state_nxt = pmg_pkg::PMG_S_DELAY;
			end
			pmg_pkg::PMG_S_DELAY: begin
				if (cnt_r == 32'h0000_0000) begin
					state_nxt = pmg_pkg::PMG_S_PULSE;
					cnt_nxt   = cfg_r.generator_width;
				end
			end
			pmg_pkg::PMG_S_PULSE: begin
				if (cnt_r <= 32'h0000_0001) begin
					state_nxt = pmg_pkg::PMG_S_REST;
					cnt_nxt   = (cfg_r.generator_period >
						cfg_r.generator_width) ?
						cfg_r.generator_period -
						cfg_r.generator_width : 32'h0000_0000;
				end
			end
			pmg_pkg::PMG_S_REST: begin
				if (cnt_r <= 32'h0000_0001) begin
					if (run_ok) begin
						state_nxt = pmg_pkg::PMG_S_PULSE;
						cnt_nxt   = cfg_r.generator_width;
					end else begin
						state_nxt = pmg_pkg::PMG_S_IDLE;
					end
				end
			end
			default: begin
				state_nxt = pmg_pkg::PMG_S_IDLE;
				cnt_nxt   = 32'h0000_0000;
			end
		endcase
		if (cfg_r.mode == pmg_pkg::PMG_GEN_OFF) begin
			state_nxt = pmg_pkg::PMG_S_IDLE;
			cnt_nxt   = 32'h0000_0000;
		end
		if (cfg_r.mode == pmg_pkg::PMG_WINDOW && !gate_or_fire_input) begin
			state_nxt = pmg_pkg::PMG_S_IDLE;
			cnt_nxt   = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= pmg_pkg::PMG_S_IDLE;
			cnt_r   <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign gen_pulse = (state_nxt == pmg_pkg::PMG_S_PULSE) &&
		(cfg_r.generator_width != 32'h0000_0000);

	////////////////////////////////////////////////////////////////////
	// rf gate
	logic                 ext_level;
	logic                 sel_pulse;

	assign ext_level = cfg_r.flipped_polarity ? ~pulse_in : pulse_in;
	assign sel_pulse = cfg_r.use_external ? ext_level : gen_pulse;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			radio_output <= 1'b1;
		else
			radio_output <= cfg_r.pulse_on ? sel_pulse : 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// sync output, delayed from pulse start
	logic                 sync_busy_r;
	logic [31:0]          sync_cnt_r;
	logic                 gen_start;

	assign gen_start = gen_pulse && (state_r != pmg_pkg::PMG_S_PULSE);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_busy_r <= 1'b0;
			sync_cnt_r  <= 32'h0000_0000;
			sync_out    <= 1'b0;
		end else begin
			sync_out <= 1'b0;
			if (gen_start) begin
				sync_busy_r <= 1'b1;
				sync_cnt_r  <= cfg_r.sync_output_delay;
			end else if (sync_busy_r) begin
				if (sync_cnt_r <= 32'h0000_0001) begin
					sync_busy_r <= 1'b0;
					sync_out    <= 1'b1;
				end
				sync_cnt_r <= sync_cnt_r - 32'h0000_0001;
			end
		end
	end

endmodule // pmg_top

// >>> pmg_top_sva.sv
/* port checker for pmg_top.
   assumes it is bound to pmg_top with core_clk as its only clock. */
`timescale 1ns/1ns
module pmg_chk (
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	// watched ports
	input wire logic               cfg_wr,
	input wire pmg_pkg::pmg_cfg_t  cfg_in,
	input wire logic               pulse_in,
	input wire logic               radio_output,
	input wire pmg_pkg::pmg_stat_t stat_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	a_pol_back:
	assert property (cfg_wr |-> ##2 stat_out.flipped_polarity ==
		$past(cfg_in.flipped_polarity, 2)) else $error("polarity back");
	a_src_back:
	assert property (cfg_wr |-> ##2 stat_out.use_external ==
		$past(cfg_in.use_external, 2)) else $error("source back");
	a_on_back:
	assert property (cfg_wr |-> ##2 stat_out.pulse_on ==
		$past(cfg_in.pulse_on, 2)) else $error("on state back");
	a_dly_back:
	assert property (cfg_wr |-> ##2 stat_out.generator_delay ==
		$past(cfg_in.generator_delay, 2)) else $error("delay back");
	a_wid_back:
	assert property (cfg_wr |-> ##2 stat_out.generator_width ==
		$past(cfg_in.generator_width, 2)) else $error("width back");
	a_sync_range:
	assert property (stat_out.sync_output_delay >= pmg_pkg::SYNC_MIN_CYC &&
		stat_out.sync_output_delay <= pmg_pkg::SYNC_MAX_CYC)
		else $error("sync delay range");
	a_off_rf_on:
	assert property (!cfg_wr[*4] ##1 !stat_out.pulse_on |-> radio_output)
		else $error("rf not on");
	a_ext_follow:
	assert property (!cfg_wr[*4] ##1 (stat_out.pulse_on &&
		stat_out.use_external) |-> radio_output ==
		($past(pulse_in, 1) ^ stat_out.flipped_polarity))
		else $error("rf not following pulse pin");
	a_gen_off_low:
	assert property (!cfg_wr[*4] ##1 (stat_out.pulse_on &&
		!stat_out.use_external && stat_out.mode == pmg_pkg::PMG_GEN_OFF)
		|-> !radio_output) else $error("generator not off");
endmodule // pmg_chk

// >>> pmg_top_test.sv
/* self-checking bench for pmg_top.
   assumes pmg_pkg, pmg_chk and pmg_src are compiled first. */
`timescale 1ns/1ns
module pmg_top_test;
	logic               core_clk, rst, cfg_wr, gate_req;
	logic               pulse_in, gate_or_fire_input;
	logic               radio_output, sync_out, p_prev, p_cur, e;
	pmg_pkg::pmg_cfg_t  cfg_in, c;
	pmg_pkg::pmg_stat_t stat_out, exp_s;
	int                 err_count, cmp_count, hi, sy;
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	pmg_top uut (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr),
		.cfg_in(cfg_in), .pulse_in(pulse_in),
		.gate_or_fire_input(gate_or_fire_input),
		.radio_output(radio_output), .sync_out(sync_out),
		.stat_out(stat_out));
	pmg_src u_src (.core_clk(core_clk), .gate_req(gate_req),
		.pulse_in(pulse_in), .gate_or_fire_input(gate_or_fire_input));
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [132:0] got, input logic [132:0] ex);
		cmp_count++;
		if (got !== ex) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask
	task automatic final_report();
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic pmg_pkg::pmg_stat_t model(pmg_pkg::pmg_cfg_t w);
		model = pmg_pkg::pmg_stat_t'(w);
		if (w.generator_period == 0)
			model.generator_period = 32'h1;
		if (w.sync_output_delay < pmg_pkg::SYNC_MIN_CYC)
			model.sync_output_delay = pmg_pkg::SYNC_MIN_CYC;
		if (w.sync_output_delay > pmg_pkg::SYNC_MAX_CYC)
			model.sync_output_delay = pmg_pkg::SYNC_MAX_CYC;
	endfunction
	// strobe stays up until idle lowers it
	task automatic put(input pmg_pkg::pmg_cfg_t w);
		@(posedge core_clk);
		cfg_in <= w;
		cfg_wr <= 1'b1;
	endtask
	task automatic idle(input int n);
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		repeat (n - 1) @(posedge core_clk);
	endtask
	task automatic watch(input int n);
		hi = 0;
		sy = 0;
		repeat (n) begin
			@(negedge core_clk);
			hi += int'(radio_output);
			sy += int'(sync_out);
		end
	endtask
	task automatic gen(input pmg_pkg::pmg_mode_t m);
		c = '0;
		c.pulse_on = 1'b1;
		c.mode = m;
		c.generator_period = 32'h14;
		c.generator_width = 32'h3;
		c.generator_delay = 32'h2;
		c.sync_output_delay = 32'hd;
		put(c);
		idle(45);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hfc4a5d1a));
		{rst, cfg_wr, gate_req} = 3'h4;
		cfg_in = '0;
		err_count = 0;
		cmp_count = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		exp_s = '0;
		exp_s.generator_period = pmg_pkg::PER_RST;
		exp_s.generator_width = pmg_pkg::WID_RST;
		exp_s.sync_output_delay = pmg_pkg::SYNC_RST;
		check(stat_out, exp_s);
		for (int i = 0; i < 20; i++) begin
			c = 133'({$urandom, $urandom, $urandom, $urandom, $urandom});
			if (i[0])
				c.sync_output_delay = 32'(i);
			if (i == 2)
				c.generator_period = 32'h0;
			put(~c);
			put(c);
			idle(2);
			@(negedge core_clk);
			check(stat_out, model(c));
		end
		for (int k = 0; k < 3; k++) begin
			c = '0;
			c.pulse_on = k != 2;
			c.use_external = 1'b1;
			c.flipped_polarity = k[0];
			put(c);
			idle(4);
			p_cur = pulse_in;
			repeat (30) begin
				@(posedge core_clk);
				p_prev = p_cur;
				p_cur = pulse_in;
				e = k == 2 | (p_cur ^ k[0]);
				@(negedge core_clk);
				check(radio_output, e);
			end
		end
		gen(pmg_pkg::PMG_FREE);
		watch(200);
		check(hi, 30);
		check(sy, 10);
		gen(pmg_pkg::PMG_GEN_OFF);
		watch(40);
		check(hi, 0);
		gen(pmg_pkg::PMG_SINGLE);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			gate_req <= 1'b1;
			watch(60);
			check(hi, 3);
			@(posedge core_clk);
			gate_req <= 1'b0;
			idle(3);
		end
		gen(pmg_pkg::PMG_WINDOW);
		@(posedge core_clk);
		gate_req <= 1'b1;
		watch(200);
		check(hi, 30);
		@(posedge core_clk);
		gate_req <= 1'b0;
		idle(5);
		watch(60);
		check(hi, 0);
		final_report();
	end
endmodule // pmg_top_test
bind pmg_top pmg_chk u_chk (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr),
	.cfg_in(cfg_in), .pulse_in(pulse_in), .radio_output(radio_output),
	.stat_out(stat_out));
